// ---- bmcs_pkg.sv ----
package bmcs_pkg;

    // host register offsets (byte addresses, 32-bit words)
    localparam logic [10:0] OFF_SWAP_NEW_VALUE   = 11'h00c;
    localparam logic [10:0] OFF_SWAP_COMPARE     = 11'h010;
    localparam logic [10:0] OFF_SWAP_CONTROL     = 11'h014;
    localparam logic [10:0] OFF_CONFIG_ROM_HDR   = 11'h018;

    // serial bus offsets of the resources (low 12 bits of the address)
    localparam logic [11:0] BUS_OFF_MGR_ID       = 12'h21c;
    localparam logic [11:0] BUS_OFF_BANDWIDTH    = 12'h220;
    localparam logic [11:0] BUS_OFF_CHAN_HIGH    = 12'h224;
    localparam logic [11:0] BUS_OFF_CHAN_LOW     = 12'h228;

    // swap control fields
    localparam int          CTRL_DONE_BIT        = 31;
    localparam int          CTRL_SEL_LSB         = 0;
    localparam int          CTRL_SEL_W           = 2;

    // config rom header fields
    localparam int          HDR_INFO_LEN_LSB     = 24;
    localparam int          HDR_CRC_LEN_LSB      = 16;
    localparam int          HDR_CRC_VAL_LSB      = 0;
    localparam logic [31:0] HDR_RESET            = 32'h0000_0000;

    // resource widths and reset values
    localparam int          MGR_ID_W             = 6;
    localparam int          BANDWIDTH_W          = 13;
    localparam logic [31:0] MGR_ID_RESET         = 32'h0000_003f;
    localparam logic [31:0] BANDWIDTH_RESET      = 32'h0000_1333;
    localparam logic [31:0] CHAN_MASK_RESET      = 32'hffff_ffff;
    localparam logic        DONE_RESET           = 1'b1;

    typedef enum logic [1:0] {
        BMCS_RES_MGR_ID    = 2'b00,
        BMCS_RES_BANDWIDTH = 2'b01,
        BMCS_RES_CHAN_HIGH = 2'b10,
        BMCS_RES_CHAN_LOW  = 2'b11
    } bmcs_res_t;

    typedef enum logic [1:0] {
        BMCS_TX_READ  = 2'b00,
        BMCS_TX_LOCK  = 2'b01,
        BMCS_TX_WRITE = 2'b10,
        BMCS_TX_OTHER = 2'b11
    } bmcs_tx_t;

endpackage

// ---- bmcs_cas_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bmcs_cas_if;
    import bmcs_pkg::*;
    logic        go;
    bmcs_res_t   sel;
    logic [31:0] cmp;
    logic [31:0] new_val;
    logic        clr;
    bmcs_res_t   rd_sel;
    logic [31:0] old_val;
    logic [31:0] rd_val;

    modport ctrl (output go, sel, cmp, new_val, clr, rd_sel, input old_val, rd_val);
    modport bank (input go, sel, cmp, new_val, clr, rd_sel, output old_val, rd_val);
endinterface
`default_nettype wire

// ---- bmcs_res_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmcs_res_bank
    import bmcs_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    bmcs_cas_if.bank   cas
);
    logic [31:0] res_q [4];
    logic [31:0] keep  [4];

    assign keep[0] = {{(32 - MGR_ID_W){1'b0}}, {MGR_ID_W{1'b1}}};
    assign keep[1] = {{(32 - BANDWIDTH_W){1'b0}}, {BANDWIDTH_W{1'b1}}};
    assign keep[2] = 32'hffff_ffff;
    assign keep[3] = 32'hffff_ffff;

    assign cas.old_val = res_q[cas.sel];
    assign cas.rd_val  = res_q[cas.rd_sel];

    // one atomic read-compare-write per cycle, upper bits kept zero
    for (genvar i = 0; i < 4; i++) begin : g_res
        localparam logic [31:0] RST_VAL = (i == 0) ? MGR_ID_RESET :
                                          (i == 1) ? BANDWIDTH_RESET : CHAN_MASK_RESET;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                res_q[i] <= RST_VAL;
            end else if (cas.clr) begin
                res_q[i] <= RST_VAL;
            end else if (cas.go && cas.sel == bmcs_res_t'(i)
                         && res_q[i] == cas.cmp) begin
                res_q[i] <= cas.new_val & keep[i];
            end
        end
    end
endmodule // bmcs_res_bank
`default_nettype wire

// ---- bmcs_top.sv ----
// How it works
// - serial bus reaches resources only by quadlet read or lock compare-swap.
// - hardware or bus reset loads 3F, 1333, FFFFFFFF, FFFFFFFF; upper bits zero.
// - swap data register holds new value, stored only when compare matches.
// - compare register at offset 10 is checked for equality against resource.
// - completion flag resets to one and sets when host swap finishes.
// - a write to swap control clears completion flag, unless a host swap finishes in the same cycle.
// - select 00 manager id, 01 bandwidth, 10 mask high, 11 mask low.
// - header register at 18 holds info block length in doublewords, default zero.
// - header holds crc coverage length, default zero; 4 means header only.
// - writing swap control starts compare-swap on the selected resource.
// - on completion data register holds resource's prior value, swap or not.
// - bus lock transactions run in hardware without software.
`timescale 1ns/1ps
`default_nettype none
module bmcs_top
    import bmcs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        BUS_RESET,
    input  wire logic        HOST_WR,
    input  wire logic        HOST_RD,
    input  wire logic [10:0] HOST_ADDR,
    input  wire logic [31:0] HOST_WDATA,
    output logic      [31:0] HOST_RDATA,
    input  wire logic        BUS_REQ,
    input  wire logic [1:0]  BUS_TYPE,
    input  wire logic [11:0] BUS_ADDR,
    input  wire logic [31:0] BUS_ARG,
    input  wire logic [31:0] BUS_DATA,
    output logic             BUS_ACK,
    output logic             BUS_ERR,
    output logic      [31:0] BUS_RDATA
);
    bmcs_cas_if cas ();

    logic [31:0] new_value_q;
    logic [31:0] compare_q;
    logic        done_q;
    bmcs_res_t   target_q;
    logic        host_pend_q;
    logic [31:0] rom_hdr_q;
    logic [31:0] host_rdata_q;
    logic        bus_ack_q;
    logic        bus_err_q;
    logic [31:0] bus_rdata_q;

    logic        bus_hit;
    bmcs_res_t   bus_sel;
    logic        bus_lock;
    logic        bus_read;
    logic        host_go;
    logic        wr_new;
    logic        wr_cmp;
    logic        wr_ctrl;
    logic        wr_hdr;
    logic [31:0] ctrl_word;
    logic [31:0] host_rdata_d;
    logic [31:0] bus_rdata_d;

    assign wr_new  = HOST_WR && HOST_ADDR == OFF_SWAP_NEW_VALUE;
    assign wr_cmp  = HOST_WR && HOST_ADDR == OFF_SWAP_COMPARE;
    assign wr_ctrl = HOST_WR && HOST_ADDR == OFF_SWAP_CONTROL;
    assign wr_hdr  = HOST_WR && HOST_ADDR == OFF_CONFIG_ROM_HDR;

    // bus address decode
    always_comb begin
        bus_hit = 1'b1;
        case (BUS_ADDR)
            BUS_OFF_MGR_ID:    bus_sel = BMCS_RES_MGR_ID;
            BUS_OFF_BANDWIDTH: bus_sel = BMCS_RES_BANDWIDTH;
            BUS_OFF_CHAN_HIGH: bus_sel = BMCS_RES_CHAN_HIGH;
            BUS_OFF_CHAN_LOW:  bus_sel = BMCS_RES_CHAN_LOW;
            default: begin
                bus_sel = BMCS_RES_MGR_ID;
                bus_hit = 1'b0;
            end
        endcase
    end

    assign bus_lock = BUS_REQ && bus_hit && BUS_TYPE == BMCS_TX_LOCK;
    assign bus_read = BUS_REQ && bus_hit && BUS_TYPE == BMCS_TX_READ;
    // bus lock owns the engine, a pending host swap waits while a bus lock is presented
    assign host_go  = host_pend_q && !bus_lock && !BUS_RESET;

    // single engine port shared by both requesters
    always_comb begin
        cas.clr     = BUS_RESET;
        cas.go      = (bus_lock && !BUS_RESET) || host_go;
        cas.rd_sel  = bus_sel;
        if (bus_lock) begin
            cas.sel     = bus_sel;
            cas.cmp     = BUS_ARG;
            cas.new_val = BUS_DATA;
        end else begin
            cas.sel     = target_q;
            cas.cmp     = compare_q;
            cas.new_val = new_value_q;
        end
    end

    bmcs_res_bank u_bank (
        .clk (CLK),
        .rst (RESET),
        .cas (cas)
    );

    // swap data register
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            new_value_q <= 32'h0000_0000;
        end else if (host_go) begin
            new_value_q <= cas.old_val;
        end else if (wr_new) begin
            new_value_q <= HOST_WDATA;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            compare_q <= 32'h0000_0000;
        end else if (wr_cmp) begin
            compare_q <= HOST_WDATA;
        end
    end

    // control: select, pending start
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            target_q    <= BMCS_RES_MGR_ID;
            host_pend_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                target_q <= bmcs_res_t'(HOST_WDATA[CTRL_SEL_LSB +: CTRL_SEL_W]);
            end
            if (wr_ctrl) begin
                host_pend_q <= 1'b1;
            end else if (host_go) begin
                host_pend_q <= 1'b0;
            end
        end
    end

    // completion flag, set wins over the write clear
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            done_q <= DONE_RESET;
        end else if (host_go) begin
            done_q <= 1'b1;
        end else if (wr_ctrl) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rom_hdr_q <= HDR_RESET;
        end else if (wr_hdr) begin
            rom_hdr_q <= HOST_WDATA;
        end
    end

    // control word: done on top, select at the bottom, reserved bits zero
    always_comb begin
        ctrl_word                             = 32'h0000_0000;
        ctrl_word[CTRL_DONE_BIT]              = done_q;
        ctrl_word[CTRL_SEL_LSB +: CTRL_SEL_W] = target_q;
    end

    // host read mux, unmapped offsets read zero
    always_comb begin
        case (HOST_ADDR)
            OFF_SWAP_NEW_VALUE: host_rdata_d = new_value_q;
            OFF_SWAP_COMPARE:   host_rdata_d = compare_q;
            OFF_SWAP_CONTROL:   host_rdata_d = ctrl_word;
            OFF_CONFIG_ROM_HDR: host_rdata_d = rom_hdr_q;
            default:            host_rdata_d = 32'h0000_0000;
        endcase
    end

    // host read data, one cycle after the strobe, held until the next read
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            host_rdata_q <= 32'h0000_0000;
        end else if (HOST_RD) begin
            host_rdata_q <= host_rdata_d;
        end
    end

    // prior value for read and lock, zero for a refused access
    always_comb begin
        bus_rdata_d = 32'h0000_0000;
        if (bus_lock || bus_read) begin
            bus_rdata_d = cas.rd_val;
        end
    end

    // bus answer one cycle after the request, error for anything else
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bus_ack_q   <= 1'b0;
            bus_err_q   <= 1'b0;
            bus_rdata_q <= 32'h0000_0000;
        end else begin
            bus_ack_q <= BUS_REQ;
            bus_err_q <= BUS_REQ && !(bus_lock || bus_read);
            if (BUS_REQ) begin
                bus_rdata_q <= bus_rdata_d;
            end
        end
    end

    assign HOST_RDATA = host_rdata_q;
    assign BUS_ACK    = bus_ack_q;
    assign BUS_ERR    = bus_err_q;
    assign BUS_RDATA  = bus_rdata_q;
endmodule // bmcs_top
`default_nettype wire

// ---- bmcs_chk_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmcs_chk
    import bmcs_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        HOST_RD,
    input wire logic [31:0] HOST_RDATA,
    input wire logic        BUS_REQ,
    input wire logic [1:0]  BUS_TYPE,
    input wire logic [11:0] BUS_ADDR,
    input wire logic        BUS_ACK,
    input wire logic        BUS_ERR,
    input wire logic [31:0] BUS_RDATA
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_ack_after_req: assert property (BUS_REQ |=> BUS_ACK)
        else $error("bus request not acknowledged");
    a_no_stray_ack: assert property (!BUS_REQ |=> !BUS_ACK && !BUS_ERR)
        else $error("ack without request");
    a_write_refused: assert property (BUS_REQ && BUS_TYPE[1] |=> BUS_ERR && BUS_RDATA == 0)
        else $error("disallowed bus access accepted");
    a_read_accepted: assert property (BUS_REQ && !BUS_TYPE[1]
        && BUS_ADDR == BUS_OFF_CHAN_LOW |=> !BUS_ERR)
        else $error("allowed bus access refused");
    a_mgr_upper_zero: assert property (BUS_REQ && BUS_ADDR == BUS_OFF_MGR_ID
        |=> BUS_RDATA[31:6] == 0)
        else $error("manager id upper bits set");
    a_bw_upper_zero: assert property (BUS_REQ && BUS_ADDR == BUS_OFF_BANDWIDTH
        |=> BUS_RDATA[31:13] == 0)
        else $error("bandwidth upper bits set");
    a_bus_data_hold: assert property (!BUS_REQ |=> $stable(BUS_RDATA))
        else $error("bus read data changed without request");
    a_host_data_hold: assert property (!HOST_RD |=> $stable(HOST_RDATA))
        else $error("host read data changed without read");
endmodule // bmcs_chk
bind bmcs_top bmcs_chk chk_u (.CLK(CLK), .RESET(RESET), .HOST_RD(HOST_RD),
    .HOST_RDATA(HOST_RDATA), .BUS_REQ(BUS_REQ), .BUS_TYPE(BUS_TYPE), .BUS_ADDR(BUS_ADDR),
    .BUS_ACK(BUS_ACK), .BUS_ERR(BUS_ERR), .BUS_RDATA(BUS_RDATA));
`default_nettype wire

// ---- bmcs_bus_node.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmcs_bus_node (
    input  wire logic        clk,
    output logic             req,
    output logic [1:0]       kind,
    output logic [11:0]      addr,
    output logic [31:0]      arg,
    output logic [31:0]      data,
    input  wire logic        ack,
    input  wire logic        err,
    input  wire logic [31:0] rdata
);
    initial {req, kind, addr, arg, data} = 79'h0;
    task automatic xact(logic [1:0] t, logic [11:0] a, logic [31:0] g, d,
                        output logic [31:0] r, output logic e);
        @(negedge clk);
        {req, kind, addr, arg, data} = {1'b1, t, a, g, d};
        @(negedge clk);
        req = 1'b0;
        // idle lines show junk, not the last value
        {kind, addr, arg, data} = ~{kind, addr, arg, data};
        r = rdata;
        e = err | ~ack;
    endtask
endmodule // bmcs_bus_node
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bmcs_pkg::*;
    logic        clk, rst, brst, hwr, hrd, breq, back, berr;
    logic [1:0]  btyp;
    logic [10:0] ha;
    logic [11:0] badr;
    logic [31:0] hwd, hrdata, barg, bdat, brdata;
    logic [31:0] cur [4];
    int          failures, samples_checked;
    bmcs_top dut_u (.CLK(clk), .RESET(rst), .BUS_RESET(brst), .HOST_WR(hwr), .HOST_RD(hrd),
        .HOST_ADDR(ha), .HOST_WDATA(hwd), .HOST_RDATA(hrdata), .BUS_REQ(breq),
        .BUS_TYPE(btyp), .BUS_ADDR(badr), .BUS_ARG(barg), .BUS_DATA(bdat),
        .BUS_ACK(back), .BUS_ERR(berr), .BUS_RDATA(brdata));
    bmcs_bus_node node_u (.clk(clk), .req(breq), .kind(btyp), .addr(badr), .arg(barg),
        .data(bdat), .ack(back), .err(berr), .rdata(brdata));
    function automatic logic [31:0] msk(int i);
        return i == 0 ? 32'h3f : i == 1 ? 32'h1fff : 32'hffff_ffff;
    endfunction
    function automatic logic [11:0] adr(int i);
        return BUS_OFF_MGR_ID + 12'(i * 4);
    endfunction
    task automatic chk(logic [31:0] got, want);
        samples_checked++;
        if (got !== want) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic hw(logic [10:0] a, logic [31:0] d);
        @(negedge clk);
        {hwr, ha, hwd} = {1'b1, a, d};
        @(negedge clk);
        hwr = 1'b0;
    endtask
    task automatic hr(logic [10:0] a, logic [31:0] w);
        @(negedge clk);
        {hrd, ha} = {1'b1, a};
        @(negedge clk);
        hrd = 1'b0;
        chk(hrdata, w);
    endtask
    task automatic bus(logic [1:0] t, logic [11:0] a, logic [31:0] g, d, wr, logic we);
        logic [31:0] r;
        logic        e;
        node_u.xact(t, a, g, d, r, e);
        chk(r, wr);
        chk({31'h0, e}, {31'h0, we});
    endtask
    task automatic rd_all;
        for (int i = 0; i < 4; i++) bus(BMCS_TX_READ, adr(i), 32'h0, 32'h0, cur[i], 1'b0);
    endtask
    task automatic t_lock;
        for (int i = 0; i < 4; i++) begin
            bus(BMCS_TX_LOCK, adr(i), ~cur[i], 32'h0, cur[i], 1'b0);
            bus(BMCS_TX_LOCK, adr(i), cur[i], 32'h1000 + 32'(i), cur[i], 1'b0);
            cur[i] = (32'h1000 + 32'(i)) & msk(i);
        end
        bus(BMCS_TX_WRITE, adr(1), 32'h0, 32'h0, 32'h0, 1'b1);
        bus(BMCS_TX_OTHER, adr(2), 32'h0, 32'h0, 32'h0, 1'b1);
        bus(BMCS_TX_READ, 12'h22c, 32'h0, 32'h0, 32'h0, 1'b1);
        rd_all();
    endtask
    task automatic t_swap;
        logic [31:0] nv;
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 4; i++) begin
                nv = 32'h5a5a_a5a5 ^ 32'(i);
                hw(OFF_SWAP_NEW_VALUE, nv);
                hw(OFF_SWAP_COMPARE, j ? ~cur[i] : cur[i]);
                @(negedge clk);
                {hwr, ha, hwd} = {1'b1, OFF_SWAP_CONTROL, 32'(i)};
                @(negedge clk);
                {hwr, hrd} = 2'b01;
                @(negedge clk);
                hrd = 1'b0;
                chk(hrdata & 32'h8000_0000, 32'h0);
                repeat (2) @(negedge clk);
                hr(OFF_SWAP_CONTROL, 32'h8000_0000 | 32'(i));
                hr(OFF_SWAP_NEW_VALUE, cur[i]);
                if (j == 0) cur[i] = nv & msk(i);
                bus(BMCS_TX_READ, adr(i), 32'h0, 32'h0, cur[i], 1'b0);
            end
        end
    endtask
    task automatic t_race;
        hw(OFF_SWAP_NEW_VALUE, 32'h0111);
        hw(OFF_SWAP_COMPARE, cur[1]);
        fork
            hw(OFF_SWAP_CONTROL, 32'h1);
            begin
                @(negedge clk);
                bus(BMCS_TX_LOCK, adr(1), cur[1], 32'h0222, cur[1], 1'b0);
            end
        join
        repeat (2) @(negedge clk);
        hr(OFF_SWAP_NEW_VALUE, 32'h0222);
        cur[1] = 32'h0222;
        rd_all();
    endtask
    task automatic t_brst;
        hw(OFF_CONFIG_ROM_HDR, 32'h0404_1234);
        hr(OFF_CONFIG_ROM_HDR, 32'h0404_1234);
        @(negedge clk);
        brst = 1'b1;
        @(negedge clk);
        brst = 1'b0;
        cur = '{MGR_ID_RESET, BANDWIDTH_RESET, CHAN_MASK_RESET, CHAN_MASK_RESET};
        rd_all();
        hr(OFF_CONFIG_ROM_HDR, 32'h0404_1234);
        // swap started under bus reset waits until it drops
        hw(OFF_SWAP_NEW_VALUE, 32'h0777);
        hw(OFF_SWAP_COMPARE, BANDWIDTH_RESET);
        @(negedge clk);
        {hwr, ha, hwd, brst} = {1'b1, OFF_SWAP_CONTROL, 32'h1, 1'b1};
        @(negedge clk);
        hwr = 1'b0;
        @(negedge clk);
        hrd = 1'b1;
        @(negedge clk);
        {hrd, brst} = 2'b00;
        chk(hrdata & 32'h8000_0000, 32'h0);
        hr(OFF_SWAP_NEW_VALUE, BANDWIDTH_RESET);
        bus(BMCS_TX_READ, adr(1), 32'h0, 32'h0, 32'h0777, 1'b0);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        failures++;
        conclude();
    end
    initial begin
        {rst, brst, hwr, hrd, ha, hwd} = {4'b1000, 43'h0};
        cur = '{MGR_ID_RESET, BANDWIDTH_RESET, CHAN_MASK_RESET, CHAN_MASK_RESET};
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd_all();
        hr(OFF_SWAP_CONTROL, 32'h8000_0000);
        hr(OFF_CONFIG_ROM_HDR, HDR_RESET);
        t_lock();
        t_swap();
        t_race();
        t_brst();
        conclude();
    end
endmodule // tb
`default_nettype wire
